// ==== inc/flash_seq_pkg.sv ====
// Constants, register map and carrier types of the flash command sequencer.
// Assumes one bus clock and a flash array that answers on that clock.
package flash_seq_pkg;
   // Register byte offsets on the AXI4-Lite slave.
   localparam logic [7:0] STAT_OFF = 8'h00;
   localparam logic [7:0] IDX_OFF = 8'h04;
   localparam logic [7:0] DATA_OFF = 8'h08;
   localparam logic [7:0] RSVD_OFF = 8'h0C;
   localparam logic [7:0] PROT_OFF = 8'h10;
   localparam logic [7:0] SEC_OFF = 8'h14;
   // Status bit positions.
   localparam int DONE_BIT = 7;
   localparam int ACC_BIT = 5;
   localparam int PV_BIT = 4;
   localparam int VHI_BIT = 1;
   localparam int VLO_BIT = 0;
   // Protection byte fields.
   localparam int LO_EN_BIT = 0;
   localparam int HI_EN_BIT = 3;
   localparam logic [7:0] PROT_RST = 8'h00;
   localparam logic [17:0] PROT_SRC = 18'h3FF0C;
   localparam logic [17:0] LOW_BASE = 18'h38000;
   localparam logic [18:0] TOP_END = 19'h40000;
   localparam logic [18:0] HI_UNIT = 19'h00800;
   localparam logic [17:0] LO_UNIT = 18'h00400;
   localparam logic [17:0] SECT_MASK = 18'h001FF;
   localparam logic [1:0] PF_BLK = 2'h3;
   // Command codes.
   localparam logic [7:0] CMD_PROG_PF = 8'h06;
   localparam logic [7:0] CMD_PROG_OTP = 8'h07;
   localparam logic [7:0] CMD_ERASE_BLK = 8'h09;
   localparam logic [7:0] CMD_ERASE_SEC = 8'h0A;
   localparam logic [7:0] CMD_UNSECURE = 8'h0B;
   // Parameter indexes expected at launch.
   localparam logic [2:0] IDX_ONE = 3'h1;
   localparam logic [2:0] IDX_LAST = 3'h5;
   localparam logic [2:0] IDX_ZERO = 3'h0;
   localparam logic [15:0] OTP_MAX = 16'h0007;
   localparam logic [17:0] OTP_BASE = 18'h00000;
   localparam logic [15:0] INVALID_RD = 16'hFFFF;
   // Flash array operations.
   localparam logic [2:0] OP_READ = 3'h0;
   localparam logic [2:0] OP_ERASE = 3'h1;
   localparam logic [2:0] OP_VERIFY = 3'h2;
   localparam logic [2:0] OP_BLANK = 3'h3;
   localparam logic [2:0] OP_PROG = 3'h4;

   typedef enum logic [7:0] {
      ST_BOOT = 8'h01, ST_IDLE = 8'h02, ST_CHECK = 8'h04, ST_ERASE = 8'h08,
      ST_VERIFY = 8'h10, ST_BLANK = 8'h20, ST_PROG = 8'h40,
      ST_FINISH = 8'h80
   } seq_state_t;

   typedef struct packed {
      logic valid;
      logic [2:0] op;
      logic [7:0] cmd;
      logic info;
      logic [17:0] addr;
      logic [63:0] data;
   } flash_req_t;

   typedef struct packed {
      logic done;
      logic rd_err;
      logic ecc_err;
      logic blank;
      logic [15:0] rdata;
   } flash_rsp_t;
endpackage

// ==== design/flash_seq.sv ====
// Flash command sequencer with AXI4-Lite registers and protection decode.
// Assumes a flash array on aclk that holds done for one cycle per request.
// Behaviour
// - Erase block: code 09 and block bits at word 0, address at word 1.
// - Launch of erase block erases, verifies, then raises the done flag.
// - Erase block with index other than 001 sets access error.
// - Misaligned erase-block address sets access error, no erase.
// - Verify read error sets high status; uncorrectable also low.
// - Erase sector: code 0A, block bits, any address inside sector.
// - Erase sector erases, then verifies, then raises the done flag.
// - Program once: code 07, phrase index 0..7, four data words.
// - Program once checks blank, programs, verifies, then raises the done flag.
// - A phrase already programmed is refused.
// - Flash reads return invalid data during program once.
// - One-time field is eight phrases, 64 bytes, in info area.
// - Program flash with index other than 101 sets access error.
// - Phrase address with low bits not 000 sets access error.
// - Program flash into protected area sets violation, no program.
// - Unsecure erases all, verifies, releases security only on pass.
// - Failed unsecure verify sets high status, security unchanged.
// - Unsecure: index not 000 is access error; protection is violation.
// - Upper size code protects 2, 4, 8 or 16 Kbytes at top.
// - Lower size code protects 1, 2, 4 or 8 Kbytes from base.
// - Protection loads from flash after reset; software may change it.
module flash_seq
   import flash_seq_pkg::*;
(
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels.
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels.
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Flash array.
   output flash_req_t freq,
   input wire flash_rsp_t frsp,
   // Processor read path and security.
   input wire logic [15:0] pf_rdata,
   output logic [15:0] pf_rd_data,
   output logic secured
);
   seq_state_t st_r, st_nxt;
   logic [15:0] param_r [6];
   logic [2:0] idx_r;
   logic [7:0] prot_r;
   logic done_r, acc_r, pv_r, vhi_r, vlo_r, sec_r;
   logic aw_r, w_r, bvalid_r, rvalid_r;
   logic [7:0] awaddr_r;
   logic [31:0] wdata_r, rdata_r;
   logic [3:0] wstrb_r;
   logic [1:0] bresp_r, rresp_r;
   logic [15:0] pf_rd_r;
   flash_req_t req_r, req_nxt;
   logic wr_go, launch, acc_set, pv_set, vhi_set, vlo_set, unsec_ok;
   logic chk_acc, chk_pv, otp_busy;
   logic [7:0] cmd;
   logic [17:0] gaddr, sect_lo;
   logic [15:0] bmask;

   // Upper and lower protected ranges; a hit in either blocks the address.
   function automatic logic prot_hit(input logic [17:0] a);
      logic [18:0] hi_lo;
      logic [17:0] lo_hi;
      hi_lo = TOP_END - (HI_UNIT << prot_r[5:4]);
      lo_hi = LOW_BASE + ((LO_UNIT << prot_r[2:1]) - 18'h00001);
      return (prot_r[HI_EN_BIT] && {1'b0, a} >= hi_lo) ||
         (prot_r[LO_EN_BIT] && a >= LOW_BASE && a <= lo_hi);
   endfunction

   // Bus handshakes; the slave takes address and data in either order.
   assign awready = !aw_r;
   assign wready = !w_r;
   assign arready = !rvalid_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign rvalid = rvalid_r;
   assign rresp = rresp_r;
   assign rdata = rdata_r;
   assign freq = req_r;
   assign pf_rd_data = pf_rd_r;
   assign secured = sec_r;
   assign wr_go = aw_r && w_r && !bvalid_r;
   assign bmask = {{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

   // Launch only from an idle sequencer with no access error or protection violation.
   assign launch = wr_go && awaddr_r == STAT_OFF && wstrb_r[0] &&
      wdata_r[DONE_BIT] && done_r && st_r == ST_IDLE && !acc_r && !pv_r;

   assign cmd = param_r[0][15:8];
   assign gaddr = {param_r[0][1:0], param_r[1]};
   assign sect_lo = gaddr & ~SECT_MASK;
   assign otp_busy = !done_r && cmd == CMD_PROG_OTP;

   // Write channel capture and response.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_r <= 1'b0;
         w_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            aw_r <= 1'b1;
            awaddr_r <= awaddr;
         end
         if (wvalid && wready) begin
            w_r <= 1'b1;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end
         if (wr_go) begin
            aw_r <= 1'b0;
            w_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= (awaddr_r <= SEC_OFF && awaddr_r[1:0] == 2'h0) ?
               2'h0 : 2'h2;
         end else if (bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Read channel; unmapped words answer with a slave error.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= 2'h0;
      end else if (arvalid && arready) begin
         rvalid_r <= 1'b1;
         rresp_r <= 2'h0;
         case (araddr)
            STAT_OFF: rdata_r <= {24'h000000, done_r, 1'b0, acc_r, pv_r,
               2'h0, vhi_r, vlo_r};
            IDX_OFF: rdata_r <= {29'h00000000, idx_r};
            DATA_OFF: rdata_r <= (idx_r <= IDX_LAST) ?
               {16'h0000, param_r[idx_r]} : 32'h0000_0000;
            RSVD_OFF: rdata_r <= 32'h0000_0000;
            PROT_OFF: rdata_r <= {24'h000000, prot_r};
            SEC_OFF: rdata_r <= {31'h00000000, sec_r};
            default: begin
               rdata_r <= 32'h0000_0000;
               rresp_r <= 2'h2;
            end
         endcase
      end else if (rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Index and parameter words; writes while a command runs are dropped.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idx_r <= 3'h0;
         for (int i = 0; i < 6; i++) begin
            param_r[i] <= 16'h0000;
         end
      end else if (wr_go && done_r) begin
         if (awaddr_r == IDX_OFF && wstrb_r[0]) begin
            idx_r <= wdata_r[2:0];
         end
         if (awaddr_r == DATA_OFF && idx_r <= IDX_LAST) begin
            param_r[idx_r] <= (param_r[idx_r] & ~bmask) |
               (wdata_r[15:0] & bmask);
         end
      end
   end

   // Launch checks, picked by command code.
   always_comb begin
      chk_acc = 1'b0;
      chk_pv = 1'b0;
      case (cmd)
         CMD_ERASE_BLK: begin
            chk_acc = idx_r != IDX_ONE;
            if (gaddr[17:16] == PF_BLK) begin
               chk_acc = chk_acc || gaddr[2:0] != 3'h0;
               chk_pv = prot_r[HI_EN_BIT] || prot_r[LO_EN_BIT];
            end else begin
               chk_acc = chk_acc || gaddr[0];
            end
         end
         CMD_ERASE_SEC: begin
            // sector found from any inner address
            chk_acc = idx_r != IDX_ONE || gaddr[17:16] != PF_BLK;
            chk_pv = prot_hit(sect_lo) || prot_hit(sect_lo | SECT_MASK);
         end
         CMD_PROG_OTP: begin
            chk_acc = idx_r != IDX_LAST || param_r[1] > OTP_MAX;
         end
         CMD_PROG_PF: begin
            chk_acc = idx_r != IDX_LAST || gaddr[2:0] != 3'h0;
            chk_pv = prot_hit(gaddr);
         end
         CMD_UNSECURE: begin
            chk_acc = idx_r != IDX_ZERO;
            chk_pv = prot_r[HI_EN_BIT] || prot_r[LO_EN_BIT];
         end
         default: chk_acc = 1'b1;
      endcase
   end

   // Sequencer: each array operation ends on the array's done pulse.
   always_comb begin
      st_nxt = st_r;
      acc_set = 1'b0;
      pv_set = 1'b0;
      vhi_set = 1'b0;
      vlo_set = 1'b0;
      unsec_ok = 1'b0;
      case (st_r)
         ST_BOOT: if (frsp.done) st_nxt = ST_IDLE;
         ST_IDLE: if (launch) st_nxt = ST_CHECK;
         ST_CHECK: begin
            acc_set = chk_acc;
            pv_set = chk_pv && !chk_acc;
            if (chk_acc || chk_pv) st_nxt = ST_FINISH;
            else if (cmd == CMD_PROG_OTP) st_nxt = ST_BLANK;
            else if (cmd == CMD_PROG_PF) st_nxt = ST_PROG;
            else st_nxt = ST_ERASE;
         end
         ST_ERASE: if (frsp.done) st_nxt = ST_VERIFY;
         ST_VERIFY: if (frsp.done) begin
            vhi_set = frsp.rd_err || frsp.ecc_err;
            vlo_set = frsp.ecc_err;
            unsec_ok = cmd == CMD_UNSECURE && !vhi_set;
            st_nxt = ST_FINISH;
         end
         ST_BLANK: if (frsp.done) begin
            acc_set = !frsp.blank;
            st_nxt = frsp.blank ? ST_PROG : ST_FINISH;
         end
         ST_PROG: if (frsp.done) st_nxt = ST_VERIFY;
         ST_FINISH: st_nxt = ST_IDLE;
         default: st_nxt = ST_IDLE;
      endcase
   end

   // Array request for the coming state.
   always_comb begin
      req_nxt = '0;
      req_nxt.cmd = cmd;
      req_nxt.addr = gaddr;
      req_nxt.data = {param_r[5], param_r[4], param_r[3], param_r[2]};
      case (st_nxt)
         ST_BOOT: begin
            req_nxt.valid = 1'b1;
            req_nxt.op = OP_READ;
            req_nxt.addr = PROT_SRC;
         end
         ST_ERASE: begin
            req_nxt.valid = 1'b1;
            req_nxt.op = OP_ERASE;
         end
         ST_VERIFY, ST_BLANK, ST_PROG: begin
            req_nxt.valid = 1'b1;
            req_nxt.op = st_nxt == ST_VERIFY ? OP_VERIFY :
               st_nxt == ST_BLANK ? OP_BLANK : OP_PROG;
            // one-time phrases live in the info area
            if (cmd == CMD_PROG_OTP) begin
               req_nxt.info = 1'b1;
               req_nxt.addr = OTP_BASE + {param_r[1][14:0], 3'h0};
            end
         end
         default: req_nxt.valid = 1'b0;
      endcase
   end

   // State and request registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= ST_BOOT;
         req_r <= '0;
      end else begin
         st_r <= st_nxt;
         req_r <= req_nxt;
      end
   end

   // Status flags; a hardware set wins over a software clear.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_r <= 1'b0;
         acc_r <= 1'b0;
         pv_r <= 1'b0;
         vhi_r <= 1'b0;
         vlo_r <= 1'b0;
      end else begin
         if (launch) done_r <= 1'b0;
         else if (st_r == ST_FINISH || (st_r == ST_BOOT && frsp.done))
            done_r <= 1'b1;
         if (acc_set) acc_r <= 1'b1;
         else if (wr_go && awaddr_r == STAT_OFF && wstrb_r[0] &&
            wdata_r[ACC_BIT]) acc_r <= 1'b0;
         if (pv_set) pv_r <= 1'b1;
         else if (wr_go && awaddr_r == STAT_OFF && wstrb_r[0] &&
            wdata_r[PV_BIT]) pv_r <= 1'b0;
         // Verify bits are cleared by the next launch.
         if (vhi_set) vhi_r <= 1'b1;
         else if (launch) vhi_r <= 1'b0;
         if (vlo_set) vlo_r <= 1'b1;
         else if (launch) vlo_r <= 1'b0;
      end
   end

   // Protection loads at boot, then follows software writes while idle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prot_r <= PROT_RST;
      end else if (st_r == ST_BOOT && frsp.done) begin
         prot_r <= frsp.rdata[7:0];
      end else if (wr_go && done_r && awaddr_r == PROT_OFF && wstrb_r[0]) begin
         prot_r <= wdata_r[7:0];
      end
   end

   // Security stays set until an unsecure passes its verify.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sec_r <= 1'b1;
      end else if (unsec_ok) begin
         sec_r <= 1'b0;
      end
   end

   // Processor reads see a fixed pattern while the one-time field programs.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pf_rd_r <= INVALID_RD;
      end else begin
         pf_rd_r <= otp_busy ? INVALID_RD : pf_rdata;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence to_finish;
      st_r == ST_FINISH ##1 st_r == ST_IDLE && done_r;
   endsequence

   launch_drops_done_a: assert property (
      launch |=> !done_r ##1 (st_r == ST_ERASE || st_r == ST_BLANK ||
      st_r == ST_PROG || st_r == ST_FINISH))
      else $error("launch did not start the command");
   blk_index_a: assert property (
      st_r == ST_CHECK && cmd == CMD_ERASE_BLK && idx_r != IDX_ONE
      |=> acc_r and to_finish)
      else $error("erase block index error missed");
   blk_align_a: assert property (
      st_r == ST_CHECK && cmd == CMD_ERASE_BLK && gaddr[17:16] == PF_BLK
      && gaddr[2:0] != 3'h0 |=> acc_r && st_r != ST_ERASE)
      else $error("misaligned erase not refused");
   verify_err_a: assert property (
      st_r == ST_VERIFY && frsp.done && frsp.ecc_err |=> vhi_r && vlo_r)
      else $error("verify error not reported");
   erase_verify_a: assert property (
      st_r == ST_ERASE && frsp.done |=> st_r == ST_VERIFY && !done_r)
      else $error("erase not followed by verify");
   otp_refuse_a: assert property (
      st_r == ST_BLANK && frsp.done && !frsp.blank |=> acc_r and to_finish)
      else $error("used phrase programmed again");
   otp_read_a: assert property (
      otp_busy |=> pf_rd_data == INVALID_RD)
      else $error("valid data during program once");
   pf_align_a: assert property (
      st_r == ST_CHECK && cmd == CMD_PROG_PF && gaddr[2:0] != 3'h0
      |=> acc_r && st_r == ST_FINISH)
      else $error("misaligned program accepted");
   pf_protect_a: assert property (
      st_r == ST_CHECK && cmd == CMD_PROG_PF && !chk_acc && prot_hit(gaddr)
      |=> pv_r && st_r != ST_PROG)
      else $error("protected program not refused");
   unsec_keep_a: assert property (
      st_r == ST_VERIFY && frsp.done && frsp.rd_err && cmd == CMD_UNSECURE
      |=> vhi_r && sec_r == $past(sec_r))
      else $error("failed unsecure changed security");
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the flash command sequencer.
// Assumes the bench acts as AXI4-Lite master and as the flash array.
module tb_top
   import flash_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   // Bus, array and processor-side signals; the ones the bench drives get values at time zero.
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic awready, wready, bvalid, arready, rvalid, secured;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd;
   flash_req_t freq;
   flash_rsp_t frsp = '0;
   logic [15:0] pf_rdata = 16'h1234;
   logic [15:0] pf_rd_data;
   int num_errors = 0;
   int check_count = 0;
   int cycles = 0;

   // The 50 MHz bus clock.
   always #10 aclk = ~aclk;

   flash_seq flash_seq_i (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .freq(freq), .frsp(frsp), .pf_rdata(pf_rdata),
      .pf_rd_data(pf_rd_data), .secured(secured));

   task automatic give_verdict();
      if (num_errors == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // A hung handshake would stall forever, so the run is capped.
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end

   task automatic chk(input string what, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Ready is looked at before the edge, so the release lands on that edge.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ap, wp;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ap = 1'b1;
      wp = 1'b1;
      while (ap || wp) begin
         @(negedge aclk);
         if (awready === 1'b1)
            ap = 1'b0;
         if (wready === 1'b1)
            wp = 1'b0;
         @(posedge aclk);
         awvalid <= ap;
         wvalid <= wp;
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask

   // Parameter loading and launch through the index and data registers.
   task automatic put(input logic [2:0] i, input logic [15:0] w);
      wr(IDX_OFF, {29'h0, i});
      wr(DATA_OFF, {16'h0, w});
   endtask

   task automatic launch(input logic [15:0] w0, w1, input logic [2:0] idx);
      put(3'h0, w0);
      put(3'h1, w1);
      wr(IDX_OFF, {29'h0, idx});
      wr(STAT_OFF, 32'h80);
   endtask

   // Status is only polled, never written, while a command runs.
   // poll only
   task automatic wait_done(input logic [31:0] exp);
      rd = 32'h0;
      while (rd[DONE_BIT] !== 1'b1)
         rd_reg(STAT_OFF);
      chk("status", rd, exp);
   endtask

   // Array side: wait for a request, then end it with a one-cycle done.
   task automatic fwait(input logic [2:0] op);
      do @(negedge aclk); while (freq.valid !== 1'b1);
      chk("flash op", {29'h0, freq.op}, {29'h0, op});
   endtask

   task automatic fdone(input logic re, ecc, blk, input logic [15:0] d);
      @(posedge aclk);
      frsp <= '{1'b1, re, ecc, blk, d};
      @(posedge aclk);
      frsp <= '0;
      @(posedge aclk);
   endtask

   // Erase then verify; the array stalls while status is read as busy.
   task automatic ev(input logic [7:0] cmd, input logic re, ecc);
      fwait(OP_ERASE);
      chk("cmd", {24'h0, freq.cmd}, {24'h0, cmd});
      rd_reg(STAT_OFF);
      chk("busy", {31'h0, rd[DONE_BIT]}, 32'h0);
      fdone(1'b0, 1'b0, 1'b0, 16'h0);
      fwait(OP_VERIFY);
      fdone(re, ecc, 1'b0, 16'h0);
   endtask

   task automatic errcase(input logic [15:0] w0, w1, input logic [2:0] ix,
                          input logic [31:0] exp);
      launch(w0, w1, ix);
      wait_done(exp);
      wr(STAT_OFF, 32'h30);
   endtask

   task automatic t_boot();
      // Look half a cycle later so the reset values are settled.
      @(negedge aclk);
      chk("secure", {31'h0, secured}, 32'h1);
      chk("reset rd", {16'h0, pf_rd_data}, {16'h0, INVALID_RD});
      chk("reset bus", {27'h0, awready, wready, arready, bvalid, rvalid},
         32'h1C);
      fwait(OP_READ);
      chk("boot addr", {14'h0, freq.addr}, {14'h0, PROT_SRC});
      fdone(1'b0, 1'b0, 1'b0, 16'h0038);
      wait_done(32'h80);
      rd_reg(PROT_OFF);
      chk("prot load", rd, 32'h38);
      wr(PROT_OFF, 32'h0);
      chk("wr okay", {30'h0, resp}, 32'h0);
      rd_reg(PROT_OFF);
      chk("prot write", rd, 32'h0);
      chk("rd okay", {30'h0, resp}, 32'h0);
      wr(RSVD_OFF, 32'hFFFFFFFF);
      rd_reg(RSVD_OFF);
      chk("reserved", rd, 32'h0);
      wr(8'h18, 32'h1);
      chk("unmapped wr", {30'h0, resp}, 32'h2);
      rd_reg(8'h18);
      chk("unmapped rd", {30'h0, resp}, 32'h2);
   endtask

   task automatic t_erase();
      launch(16'h0903, 16'h0000, 3'h1);
      ev(CMD_ERASE_BLK, 1'b1, 1'b0);
      wait_done(32'h82);
      launch(16'h0A03, 16'h1234, 3'h1);
      ev(CMD_ERASE_SEC, 1'b0, 1'b1);
      wait_done(32'h83);
   endtask

   task automatic t_errors();
      errcase(16'h0903, 16'h0000, 3'h0, 32'hA0);
      errcase(16'h0903, 16'h0004, 3'h1, 32'hA0);
      errcase(16'h0900, 16'h0001, 3'h1, 32'hA0);
      errcase(16'h0B00, 16'h0000, 3'h1, 32'hA0);
      errcase(16'h0603, 16'h0000, 3'h1, 32'hA0);
      errcase(16'h0603, 16'h0003, 3'h5, 32'hA0);
      errcase(16'h0700, 16'h0008, 3'h5, 32'hA0);
      errcase(16'h0100, 16'h0000, 3'h0, 32'hA0);
      wr(PROT_OFF, 32'h08);
      errcase(16'h0A03, 16'hFC10, 3'h1, 32'h90);
      errcase(16'h0903, 16'h0000, 3'h1, 32'h90);
      errcase(16'h0B00, 16'h0000, 3'h0, 32'h90);
   endtask

   // Each size code protects the lowest phrase of the top range and the
   // highest phrase of the lower range.
   task automatic t_ranges();
      logic [17:0] a;
      logic [17:0] hi_base [4];
      logic [17:0] lo_last [4];
      hi_base = '{18'h3F800, 18'h3F000, 18'h3E000, 18'h3C000};
      lo_last = '{18'h383F8, 18'h387F8, 18'h38FF8, 18'h39FF8};
      for (int k = 0; k < 4; k++) begin
         a = hi_base[k];
         wr(PROT_OFF, {26'h0, 2'(k), 4'h8});
         errcase({8'h06, 6'h0, a[17:16]}, a[15:0], 3'h5, 32'h90);
         a = lo_last[k];
         wr(PROT_OFF, {29'h0, 2'(k), 1'b1});
         errcase({8'h06, 6'h0, a[17:16]}, a[15:0], 3'h5, 32'h90);
      end
      wr(PROT_OFF, 32'h08);
      launch(16'h0603, 16'hF7F8, 3'h5);
      fwait(OP_PROG);
      chk("prog addr", {14'h0, freq.addr}, 32'h3F7F8);
      fdone(1'b0, 1'b0, 1'b0, 16'h0);
      fwait(OP_VERIFY);
      fdone(1'b0, 1'b0, 1'b0, 16'h0);
      wait_done(32'h80);
      wr(PROT_OFF, 32'h0);
   endtask

   task automatic t_otp();
      put(3'h2, 16'h1111);
      put(3'h3, 16'h2222);
      put(3'h4, 16'h3333);
      put(3'h5, 16'h4444);
      launch(16'h0700, 16'h0007, 3'h5);
      fwait(OP_BLANK);
      chk("otp addr", {14'h0, freq.addr}, {14'h0, OTP_BASE} + 32'h38);
      chk("otp info", {31'h0, freq.info}, 32'h1);
      chk("invalid rd", {16'h0, pf_rd_data}, {16'h0, INVALID_RD});
      fdone(1'b0, 1'b0, 1'b1, 16'h0);
      fwait(OP_PROG);
      chk("otp lo", freq.data[31:0], 32'h22221111);
      chk("otp hi", freq.data[63:32], 32'h44443333);
      fdone(1'b0, 1'b0, 1'b0, 16'h0);
      fwait(OP_VERIFY);
      fdone(1'b0, 1'b0, 1'b0, 16'h0);
      wait_done(32'h80);
      @(negedge aclk);
      chk("normal rd", {16'h0, pf_rd_data}, 32'h1234);
      launch(16'h0700, 16'h0007, 3'h5);
      fwait(OP_BLANK);
      fdone(1'b0, 1'b0, 1'b0, 16'h0);
      wait_done(32'hA0);
      wr(STAT_OFF, 32'h30);
   endtask

   // A failed verify keeps the part secure; a clean one releases it.
   task automatic t_unsec();
      launch(16'h0B00, 16'h0000, 3'h0);
      ev(CMD_UNSECURE, 1'b1, 1'b0);
      wait_done(32'h82);
      chk("still secure", {31'h0, secured}, 32'h1);
      launch(16'h0B00, 16'h0000, 3'h0);
      ev(CMD_UNSECURE, 1'b0, 1'b0);
      wait_done(32'h80);
      rd_reg(SEC_OFF);
      chk("released", rd, 32'h0);
      chk("released pin", {31'h0, secured}, 32'h0);
   endtask

   // Reset for two cycles, then the scenarios in turn.
   initial begin
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_boot();
      t_erase();
      t_errors();
      t_ranges();
      t_otp();
      t_unsec();
      give_verdict();
   end
endmodule
